// >>> lpw_chan.sv
module lpw_chan (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  // Timing
  input  wire logic [lpw_pkg::CNT_W-1:0] cnt,
  input  wire logic [lpw_pkg::CNT_W-1:0] mask,
  input  wire logic [lpw_pkg::CNT_W-1:0] offset,
  input  wire logic [lpw_pkg::CNT_W-1:0] duty,
  // Mode
  input  wire logic                      direct,
  input  wire logic                      pin,
  input  wire logic                      enable,
  // Sink control
  output logic                           on
);
  import lpw_pkg::*;

  logic [CNT_W-1:0] pos;

  // Offset moves this channel's window along the shared counter
  assign pos = (cnt + offset) & mask;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      on <= 1'b0;
    end else if (ce) begin
      on <= enable && (direct ? pin : (pos < duty));
    end
  end

endmodule : lpw_chan

// >>> lpw_host.sv
module lpw_host #(
  parameter int PER = 250,
  parameter int HI  = 125
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Brightness pin
  output logic      pwm_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Period and high time are whole multiples of 25 clocks, so the tick ratio is exact
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt     <= 0;
      pwm_pin <= 1'b0;
    end else begin
      cnt     <= (cnt == PER - 1) ? 0 : cnt + 1;
      pwm_pin <= cnt < HI;
    end
  end
endmodule : lpw_host

// >>> lpw_led_dimming_pwm_control.sv
module lpw_led_dimming_pwm_control #(
  parameter int unsigned DISCH_CYCLES = lpw_pkg::DISCH_CYCLES
) (
  // Clock, reset, freeze
  input  wire logic                                       clock,
  input  wire logic                                       rst_n,
  input  wire logic                                       ce,
  // AHB-Lite slave
  input  wire logic                                       hsel,
  input  wire logic [31:0]                                haddr,
  input  wire logic [1:0]                                 htrans,
  input  wire logic                                       hwrite,
  input  wire logic [2:0]                                 hsize,
  input  wire logic [31:0]                                hwdata,
  input  wire logic                                       hready,
  output logic      [31:0]                                hrdata,
  output logic                                            hreadyout,
  output logic                                            hresp,
  // Pins
  input  wire logic                                       en_pin,
  input  wire logic                                       pwm_pin,
  input  wire logic                                       discharge_ovp_pin,
  input  wire logic [2:0]                                 string_config_resistor,
  input  wire logic [2:0]                                 led_pwm_freq_resistor,
  input  wire logic [2:0]                                 mode_resistor,
  // Sinks and boost
  output logic      [lpw_pkg::NCH-1:0]                    string_sink_output,
  output logic      [lpw_pkg::NCH*lpw_pkg::CUR_W-1:0]     string_current_code,
  output logic      [lpw_pkg::CUR_W-1:0]                  dim_level,
  output logic                                            boost_enable,
  output logic                                            power_fet_on,
  output logic                                            discharge_on,
  output logic                                            boost_overvoltage_high_fault
);
  import lpw_pkg::*;

  localparam int DW = $clog2(DISCH_CYCLES + 1);
  localparam logic [DW-1:0] DISCH_LAST = DW'(DISCH_CYCLES - 1);
  localparam logic [DW-1:0] DCNT_ONE   = DW'(1);

  // Pin synchronisers
  logic [11:0]  sync_q;
  logic         en_s;
  logic         pwm_s;
  logic         ovp_s;
  lpw_straps_t  straps_s;

  lpw_sync #(.W(12)) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .ce    (ce),
    .d     ({en_pin, pwm_pin, discharge_ovp_pin, string_config_resistor,
             led_pwm_freq_resistor, mode_resistor}),
    .q     (sync_q)
  );

  assign en_s     = sync_q[11];
  assign pwm_s    = sync_q[10];
  assign ovp_s    = sync_q[9];
  assign straps_s = lpw_straps_t'(sync_q[8:0]);

  // Power sequencing
  lpw_state_t   state;
  lpw_state_t   next_state;
  logic [DW-1:0] dcnt;
  lpw_straps_t  straps;
  logic         fault;
  logic         active;

  always_comb begin
    next_state = state;
    case (state)
      ST_SHUT: begin
        if (en_s) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (ovp_s) begin
          next_state = ST_FAULT;
        end else if (!en_s) begin
          next_state = ST_DISCH;
        end
      end
      ST_DISCH: begin
        if (ovp_s) begin
          next_state = ST_FAULT;
        end else if (dcnt == DISCH_LAST) begin
          next_state = ST_SHUT;
        end
      end
      default: begin
        // Recovery waits for the overvoltage to clear
        if (!ovp_s) begin
          next_state = en_s ? ST_ACTIVE : ST_DISCH;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_SHUT;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Discharge runs its full time even if enable returns meanwhile
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dcnt <= '0;
    end else if (ce) begin
      // Clears on the exit edge, so a new discharge always starts from zero
      dcnt <= (state == ST_DISCH && next_state == ST_DISCH) ? dcnt + DCNT_ONE : '0;
    end
  end

  // Straps follow the pins only while shut down
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      straps <= '0;
    end else if (ce && state == ST_SHUT) begin
      straps <= straps_s;
    end
  end

  assign active       = (state == ST_ACTIVE);
  assign boost_enable = active;
  assign power_fet_on = active;
  assign discharge_on = (state == ST_DISCH);
  assign boost_overvoltage_high_fault = fault;

  // 20 MHz oscillator tick
  logic [4:0]       osc_acc;
  logic             osc_tick;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] mask;

  assign osc_tick = (osc_acc >= OSC_MOD - OSC_INC);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      osc_acc <= '0;
    end else if (ce) begin
      osc_acc <= osc_tick ? osc_acc + OSC_INC - OSC_MOD : osc_acc + OSC_INC;
    end
  end

  // Period is 2^(17-code) ticks; never touched by input PWM edges
  assign mask = CNT_MASK >> straps.freq;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (ce && osc_tick) begin
      cnt <= (cnt + CNT_ONE) & mask;
    end
  end

  // Input duty measurement in oscillator ticks
  logic              pwm_d;
  logic              pwm_rise;
  logic [MEAS_W-1:0] hi_cnt;
  logic [MEAS_W-1:0] per_cnt;
  logic [MEAS_W-1:0] den;
  logic [MEAS_W+1:0] rem;
  logic [MEAS_W+1:0] rem_sh;
  logic              ge;
  logic [BRIGHT_W-1:0] quo;
  logic [4:0]        div_cnt;
  logic [BRIGHT_W-1:0] pin_bright;

  assign pwm_rise = pwm_s && !pwm_d;
  assign rem_sh   = {rem[MEAS_W:0], 1'b0};
  assign ge       = (rem_sh >= {2'h0, den});

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pwm_d   <= 1'b0;
      hi_cnt  <= '0;
      per_cnt <= '0;
    end else if (ce) begin
      pwm_d <= pwm_s;
      if (pwm_rise) begin
        hi_cnt  <= '0;
        per_cnt <= '0;
      end else if (osc_tick && per_cnt != MEAS_MAX) begin
        per_cnt <= per_cnt + MEAS_ONE;
        hi_cnt  <= hi_cnt + (pwm_s ? MEAS_ONE : '0);
      end
    end
  end

  // Serial divider: one quotient bit per clock, 16 clocks per edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rem        <= '0;
      den        <= '0;
      quo        <= '0;
      div_cnt    <= '0;
      pin_bright <= '0;
    end else if (ce) begin
      if (pwm_rise) begin
        rem     <= {2'h0, hi_cnt};
        den     <= per_cnt;
        quo     <= '0;
        div_cnt <= DIV_STEPS;
      end else if (div_cnt != '0) begin
        rem     <= ge ? rem_sh - {2'h0, den} : rem_sh;
        quo     <= {quo[BRIGHT_W-2:0], ge};
        div_cnt <= div_cnt - 5'h01;
        if (div_cnt == 5'h01) begin
          pin_bright <= {quo[BRIGHT_W-2:0], ge};
        end
      end else if (per_cnt == MEAS_MAX) begin
        // No edges: a static pin means fully off or fully on
        pin_bright <= pwm_s ? BRT_FULL : '0;
      end
    end
  end

  // Register bus
  lpw_ctrl_t           ctrl;
  logic [BRIGHT_W-1:0] disp_bright;
  logic [CUR_W-1:0]    cur [NCH];
  logic                req;
  logic                wr_pend;
  logic [ADDR_W-1:0]   wr_addr;
  logic [31:0]         rd;
  logic [2:0]          rd_idx;
  lpw_status_t         status;
  logic [BRIGHT_W-1:0] bright;

  assign req       = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign rd_idx    = 3'((haddr[ADDR_W-1:0] - A_CUR0) >> REG_SHIFT);
  assign status    = '{straps: straps, state: state, fault: fault};

  always_comb begin
    rd = '0;
    if (haddr[31:ADDR_W] != '0) begin
      rd = '0;
    end else if (haddr[ADDR_W-1:0] == A_CTRL) begin
      rd = 32'(ctrl);
    end else if (haddr[ADDR_W-1:0] == A_BRIGHT) begin
      rd = 32'(disp_bright);
    end else if (haddr[ADDR_W-1:0] == A_STATUS) begin
      rd = 32'(status);
    end else if (haddr[ADDR_W-1:0] == A_MEAS) begin
      rd = 32'(bright);
    end else if (haddr[ADDR_W-1:0] >= A_CUR0 && haddr[ADDR_W-1:0] <= A_CUR_LAST
                 && haddr[REG_SHIFT-1:0] == '0) begin
      rd = 32'(cur[rd_idx]);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata  <= '0;
    end else if (ce) begin
      wr_pend <= req && hwrite && (haddr[31:ADDR_W] == '0);
      wr_addr <= haddr[ADDR_W-1:0];
      if (req && !hwrite) begin
        hrdata <= rd;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl        <= CTRL_RST;
      disp_bright <= '0;
    end else if (ce && wr_pend) begin
      if (wr_addr == A_CTRL) begin
        ctrl <= lpw_ctrl_t'(hwdata[$bits(lpw_ctrl_t)-1:0]);
      end else if (wr_addr == A_BRIGHT) begin
        disp_bright <= hwdata[BRIGHT_W-1:0];
      end
    end
  end

  // Overvoltage flag: a new fault beats a same-cycle clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fault <= 1'b0;
    end else if (ce) begin
      if (next_state == ST_FAULT && state != ST_FAULT) begin
        fault <= 1'b1;
      end else if (wr_pend && wr_addr == A_STATUS && hwdata[0]) begin
        fault <= 1'b0;
      end
    end
  end

  // Brightness path and dimming mode
  logic                serial_src;
  logic [BRIGHT_W-1:0] pwm_b;
  logic [BRIGHT_W-1:0] next_pwm_b;
  logic [CUR_W-1:0]    next_dim;
  logic [CNT_W-1:0]    duty;

  // Register source only counts when the serial port is strapped on
  assign serial_src = ctrl.src && straps.serial;
  assign bright     = serial_src ? disp_bright : pin_bright;

  always_comb begin
    next_pwm_b = BRT_FULL;
    next_dim   = CUR_FULL;
    case (straps.dim)
      DIM_PHASE: begin
        next_pwm_b = bright;
      end
      DIM_HYBRID: begin
        if (!ctrl.hyb_zero && bright < HYB_THR) begin
          next_pwm_b = BRIGHT_W'(bright << HYB_SHIFT);
          next_dim   = HYB_DIM;
        end else begin
          next_dim = bright[BRIGHT_W-1 -: CUR_W];
        end
      end
      DIM_CURRENT: begin
        next_dim = bright[BRIGHT_W-1 -: CUR_W];
      end
      default: begin
        next_pwm_b = BRT_FULL;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pwm_b     <= '0;
      dim_level <= '0;
    end else if (ce) begin
      pwm_b     <= next_pwm_b;
      dim_level <= next_dim;
    end
  end

  // High codes keep only the top bits: 16 bits down to 10
  assign duty = {pwm_b, 1'b0} >> straps.freq;

  // Per-channel phase, waveform and current code
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [2:0]       grp;
    logic             used;
    logic [CNT_W-1:0] offset;

    assign grp    = lpw_group(straps.cfg, c);
    assign used   = lpw_used(straps.cfg, c);
    assign offset = {16'(grp * lpw_step(straps.cfg)), 1'b0} >> straps.freq;

    lpw_chan u_chan (
      .clock  (clock),
      .rst_n  (rst_n),
      .ce     (ce),
      .cnt    (cnt),
      .mask   (mask),
      .offset (offset),
      .duty   (duty),
      .direct (straps.dim == DIM_DIRECT),
      .pin    (pwm_s),
      .enable (active && used),
      .on     (string_sink_output[c])
    );

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        cur[c] <= CUR_FULL;
      end else if (ce && wr_pend && wr_addr == A_CUR0 + ADDR_W'(c << REG_SHIFT)) begin
        cur[c] <= hwdata[CUR_W-1:0];
      end
    end

    assign string_current_code[c*CUR_W +: CUR_W] = cur[c];

    property p_unused_off;
      @(posedge clock) disable iff (!rst_n)
      !used |=> !string_sink_output[c];
    endproperty
    a_unused_off: assert property (p_unused_off) else $error("unused channel driven");
  end

  // Checks
  property p_disch_entry;
    @(posedge clock) disable iff (!rst_n)
    ce && active && !en_s && !ovp_s |=> discharge_on && !boost_enable && !power_fet_on;
  endproperty
  a_disch_entry: assert property (p_disch_entry) else $error("no discharge on enable low");

  property p_disch_end;
    @(posedge clock) disable iff (!rst_n)
    ce && discharge_on && !ovp_s && dcnt == DISCH_LAST |=> state == ST_SHUT && dcnt == '0;
  endproperty
  a_disch_end: assert property (p_disch_end) else $error("discharge did not end");

  property p_disch_count;
    @(posedge clock) disable iff (!rst_n)
    ce && discharge_on && !ovp_s && dcnt != DISCH_LAST |=> discharge_on && dcnt == $past(dcnt) + DCNT_ONE;
  endproperty
  a_disch_count: assert property (p_disch_count) else $error("discharge timer slip");

  property p_ovp;
    @(posedge clock) disable iff (!rst_n)
    ce && ovp_s && state != ST_SHUT |=> state == ST_FAULT && boost_overvoltage_high_fault;
  endproperty
  a_ovp: assert property (p_ovp) else $error("overvoltage not handled");

  property p_reset_vals;
    @(posedge clock) disable iff (!rst_n)
    $rose(rst_n) |-> string_current_code == {NCH{CUR_FULL}} && !ctrl.src && ctrl.sloper_en;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

  property p_cfg_hold;
    @(posedge clock) disable iff (!rst_n)
    state != ST_SHUT |=> $stable(straps);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed while on");

  property p_cnt_tick;
    @(posedge clock) disable iff (!rst_n)
    !(ce && osc_tick) |=> $stable(cnt);
  endproperty
  a_cnt_tick: assert property (p_cnt_tick) else $error("counter moved off tick");

  property p_cnt_range;
    @(posedge clock) disable iff (!rst_n)
    $stable(straps) |-> (cnt & ~mask) == '0;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("counter beyond period");

  property p_direct;
    @(posedge clock) disable iff (!rst_n)
    ce && active && straps.dim == DIM_DIRECT |=> string_sink_output[0] == $past(pwm_s);
  endproperty
  a_direct: assert property (p_direct) else $error("direct mode mismatch");

  property p_hybrid;
    @(posedge clock) disable iff (!rst_n)
    ce && straps.dim == DIM_HYBRID && !ctrl.hyb_zero && bright < HYB_THR |=> dim_level == HYB_DIM;
  endproperty
  a_hybrid: assert property (p_hybrid) else $error("hybrid threshold wrong");

  c_disch_done: cover property (@(posedge clock) disable iff (!rst_n) discharge_on ##1 state == ST_SHUT);
  c_fault: cover property (@(posedge clock) disable iff (!rst_n) state == ST_FAULT);
  c_phase_run: cover property (@(posedge clock) disable iff (!rst_n)
    active && straps.dim == DIM_PHASE && string_sink_output[0] && !string_sink_output[1]);

endmodule : lpw_led_dimming_pwm_control

// >>> lpw_pkg.sv
// Behaviour
// - Enable low stops boost, sinks, FET; discharges.
// - Discharge lasts 400 ms, then full shutdown.
// - Discharge comparator overvoltage enters fault recovery.
// - Per-string 12-bit code scales sink current.
// - Current codes reset to full scale.
// - Sample string config code, assign phases.
// - Config held until passing through shutdown.
// - Groups phase-shifted evenly by group count.
// - Eight string configurations, grouped channels identical.
// - LED PWM runs from oscillator, not input.
// - PWM counts 20 MHz oscillator periods.
// - Frequency code selects one of eight frequencies.
// - Resolution 16 bits down to 10 bits.
// - Phase-shift and hybrid frequency ignore input PWM.
// - Global brightness from pin or register.
// - Source select routes pin or brightness register.
// - Source select defaults to PWM pin.
// - Sloper on by default, sloper/dither programmable.
// - Mode code selects dimming mode and serial enable.
// - Phase-shift mode: constant delay between neighbours.
// - Direct mode follows input PWM edges.
// - Hybrid threshold 12.5 percent or zero.
package lpw_pkg;

  localparam int NCH      = 6;
  localparam int CNT_W    = 17;
  localparam int BRIGHT_W = 16;
  localparam int CUR_W    = 12;
  localparam int MEAS_W   = 20;
  localparam int ADDR_W   = 8;

  // Discharge time and its cycle count at 125 MHz
  localparam int CLK_PERIOD_NS = 8;
  localparam int DISCH_TIME_MS = 400;
  localparam int DISCH_CYCLES  = DISCH_TIME_MS * 1000000 / CLK_PERIOD_NS;

  // 20 MHz tick from 125 MHz: add 4, wrap at 25
  localparam logic [4:0] OSC_INC = 5'h04;
  localparam logic [4:0] OSC_MOD = 5'h19;

  localparam logic [CNT_W-1:0]    CNT_MASK  = 17'h1ffff;
  localparam logic [CNT_W-1:0]    CNT_ONE   = 17'h00001;
  localparam logic [MEAS_W-1:0]   MEAS_MAX  = 20'hfffff;
  localparam logic [MEAS_W-1:0]   MEAS_ONE  = 20'h00001;
  localparam logic [4:0]          DIV_STEPS = 5'h10;
  localparam logic [CUR_W-1:0]    CUR_FULL  = 12'hfff;
  localparam logic [CUR_W-1:0]    HYB_DIM   = 12'h1ff;
  localparam logic [BRIGHT_W-1:0] BRT_FULL  = 16'hffff;
  localparam logic [BRIGHT_W-1:0] HYB_THR   = 16'h2000;
  localparam int                  HYB_SHIFT = 3;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] A_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] A_BRIGHT   = 8'h04;
  localparam logic [ADDR_W-1:0] A_STATUS   = 8'h08;
  localparam logic [ADDR_W-1:0] A_MEAS     = 8'h0c;
  localparam logic [ADDR_W-1:0] A_CUR0     = 8'h10;
  localparam logic [ADDR_W-1:0] A_CUR_LAST = 8'h24;
  localparam int                REG_SHIFT  = 2;

  typedef enum logic [1:0] {DIM_PHASE, DIM_HYBRID, DIM_CURRENT, DIM_DIRECT} lpw_dim_t;
  typedef enum logic [1:0] {ST_SHUT, ST_ACTIVE, ST_DISCH, ST_FAULT} lpw_state_t;

  typedef struct packed {
    logic [2:0] cfg;
    logic [2:0] freq;
    logic       serial;
    lpw_dim_t   dim;
  } lpw_straps_t;

  typedef struct packed {
    logic       hyb_zero;
    logic [3:0] dither;
    logic       sloper_en;
    logic       src;
  } lpw_ctrl_t;

  typedef struct packed {
    lpw_straps_t straps;
    lpw_state_t  state;
    logic        fault;
  } lpw_status_t;

  localparam lpw_ctrl_t CTRL_RST = '{hyb_zero: 1'b0, dither: 4'h0, sloper_en: 1'b1, src: 1'b0};

  function automatic logic [2:0] lpw_group(input logic [2:0] cfg, input int ch);
    case (cfg)
      3'h5:    return 3'(ch / 2);
      3'h6:    return 3'(ch / 3);
      3'h7:    return 3'h0;
      default: return 3'(ch);
    endcase
  endfunction : lpw_group

  function automatic logic lpw_used(input logic [2:0] cfg, input int ch);
    return (cfg >= 3'h5) || (ch < NCH - int'(cfg));
  endfunction : lpw_used

  // Phase step per group as a fraction of the period, scaled by 2^16
  function automatic logic [15:0] lpw_step(input logic [2:0] cfg);
    case (cfg)
      3'h0:    return 16'h2aab;
      3'h1:    return 16'h3333;
      3'h2:    return 16'h4000;
      3'h3:    return 16'h5555;
      3'h4:    return 16'h8000;
      3'h5:    return 16'h5555;
      3'h6:    return 16'h8000;
      default: return 16'h0000;
    endcase
  endfunction : lpw_step

endpackage : lpw_pkg

// >>> lpw_sync.sv
module lpw_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : lpw_sync

// >>> tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lpw_pkg::*;
  logic        clock, rst_n, ce, hwrite, en, ovp, pwm;
  logic [1:0]  htrans;
  logic [8:0]  straps;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic        hreadyout, hresp, boost, fet, dis, flt;
  logic [5:0]  sinks;
  logic [71:0] cur;
  logic [11:0] dim;
  int          error_cnt, n_compared, cyc, n;

  lpw_led_dimming_pwm_control #(.DISCH_CYCLES(20)) i_lpw_led_dimming_pwm_control (
    .clock(clock), .rst_n(rst_n), .ce(ce), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .en_pin(en), .pwm_pin(pwm), .discharge_ovp_pin(ovp),
    .string_config_resistor(straps[2:0]), .led_pwm_freq_resistor(straps[5:3]),
    .mode_resistor(straps[8:6]), .string_sink_output(sinks), .string_current_code(cur),
    .dim_level(dim), .boost_enable(boost), .power_fet_on(fet), .discharge_on(dis),
    .boost_overvoltage_high_fault(flt));
  lpw_host i_lpw_host (.clock(clock), .rst_n(rst_n), .pwm_pin(pwm));

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // One single AHB-Lite transfer; read data taken at the edge ending the data phase
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    rst_n = 1'b0; ce = 1'b1; hwrite = 1'b0; en = 1'b0; ovp = 1'b0;
    htrans = 2'h0; haddr = 32'h0; hwdata = 32'h0;
    straps = 9'h138; // cfg 0, freq 7, mode 4: phase-shift with serial
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    chk("cur_port", {31'h0, cur === {6{12'hfff}}}, 32'h1);
    for (int i = 0; i < NCH; i++) begin
      xfer(1'b0, 32'(A_CUR0) + 4 * i, 32'h0);
      chk("cur_reg", r, 32'hfff);
    end
    xfer(1'b0, 32'(A_CTRL), 32'h0);
    chk("ctrl_rst", r, 32'h2);
    xfer(1'b0, 32'h80, 32'h0);
    chk("unmapped", r, 32'h0);
    xfer(1'b1, 32'(A_CUR0) + 8, 32'h5a5);
    xfer(1'b0, 32'(A_CUR0) + 8, 32'h0);
    chk("cur2_reg", r, 32'h5a5);
    chk("cur2_port", {20'h0, cur[35:24]}, 32'h5a5);
    en <= 1'b1;
    do @(negedge clock); while (boost !== 1'b1);
    chk("fet_on", {31'h0, fet}, 32'h1);
    chk("dim_phase", {20'h0, dim}, 32'hfff);
    xfer(1'b0, 32'(A_STATUS), 32'h0);
    chk("status", r, 32'h1e2);
    repeat (1500) @(posedge clock);
    xfer(1'b0, 32'(A_MEAS), 32'h0);
    chk("pin_bright", r, 32'h8000);
    xfer(1'b1, 32'(A_BRIGHT), 32'h1234);
    xfer(1'b1, 32'(A_CTRL), 32'h3);
    xfer(1'b0, 32'(A_MEAS), 32'h0);
    chk("reg_bright", r, 32'h1234);
    en <= 1'b0;
    do @(negedge clock); while (dis !== 1'b1);
    chk("off", {30'h0, boost, fet}, 32'h0);
    // Sinks are registered, so they drop one edge after the state
    @(negedge clock);
    chk("sinks_off", {31'h0, |sinks}, 32'h0);
    n = 1;
    while (dis === 1'b1) begin
      n++;
      @(negedge clock);
    end
    chk("disch_len", n, 32'd20);
    @(posedge clock);
    straps <= 9'h1ff; // cfg 7, freq 7, mode 7: direct with serial
    en     <= 1'b1;
    do @(negedge clock); while (boost !== 1'b1);
    do @(negedge clock); while (pwm !== 1'b0);
    do @(negedge clock); while (pwm !== 1'b1);
    repeat (4) @(negedge clock);
    chk("direct_hi", {26'h0, sinks}, 32'h3f);
    do @(negedge clock); while (pwm !== 1'b0);
    repeat (4) @(negedge clock);
    chk("direct_lo", {26'h0, sinks}, 32'h0);
    chk("dim_direct", {20'h0, dim}, 32'hfff);
    @(posedge clock);
    ovp <= 1'b1;
    repeat (5) @(negedge clock);
    chk("ovp_flag", {31'h0, flt}, 32'h1);
    xfer(1'b0, 32'(A_STATUS), 32'h0);
    chk("ovp_status", r, 32'hfff);
    ovp <= 1'b0;
    wrap_up();
  end
endmodule : tb
